// [core/brs_defs.vh]
// constants shared by the brownout reset sequencer files
`ifndef BRS_DEFS_VH
`define BRS_DEFS_VH

// ****************************************
// timing
// ****************************************
`define BRS_CLK_HZ          50000000
`define BRS_DELAY_US        3000
// least time in whole cycles: 3000 us at 50 cycles per us, no rounding
`define BRS_DELAY_CYC       ((`BRS_DELAY_US * (`BRS_CLK_HZ / 1000000) + 0) )

// ****************************************
// idle timer preset
// ****************************************
`define BRS_PRESET_BASE     8'hf0
`define BRS_PRESET_LOW_MASK 8'h0f
`define BRS_TIMER_W         8
`define BRS_TIMER_ZERO      8'h00
`define BRS_DELAY_W         18

`endif

// [core/brs_delay.v]
// power-up delay counter for the brownout reset sequencer
`timescale 1ns/1ps
`include "brs_defs.vh"

module brs_delay #(
  parameter CYCLES = `BRS_DELAY_CYC
) (
  input  wire clk,
  input  wire nrst,
  input  wire restart,
  output reg  done_q
);

  reg  [`BRS_DELAY_W-1:0] cnt_q;
  // load value kept at 32 bits, then cut to the counter width on purpose
  wire [31:0]             load_w = CYCLES - 1;

  // ****************************************
  // count down from restart, flag when spent
  // ****************************************
  always @(posedge clk) begin
    if (!nrst || restart) begin
      cnt_q  <= load_w[`BRS_DELAY_W-1:0];
      done_q <= 1'b0;
    end else if (cnt_q != {`BRS_DELAY_W{1'b0}}) begin
      cnt_q <= cnt_q - 1'b1;
    end else begin
      done_q <= 1'b1;
    end
  end

endmodule

// [core/brs_idle_timer.v]
// idle timer countdown used to time the reset release
`timescale 1ns/1ps
`include "brs_defs.vh"

module brs_idle_timer (
  input  wire                    clk,
  input  wire                    nrst,
  input  wire                    preset,
  input  wire [3:0]              preset_low,
  input  wire                    run,
  output reg  [`BRS_TIMER_W-1:0] count_q,
  output reg                     underflow_q
);

  // ****************************************
  // preset wins over counting; underflow is a one-cycle pulse
  // ****************************************
  always @(posedge clk) begin
    if (!nrst) begin
      count_q     <= `BRS_PRESET_BASE;
      underflow_q <= 1'b0;
    end else if (preset) begin
      count_q     <= `BRS_PRESET_BASE | {4'h0, preset_low};
      underflow_q <= 1'b0;
    end else if (run) begin
      count_q     <= count_q - 1'b1;
      underflow_q <= (count_q == `BRS_TIMER_ZERO);
    end else begin
      underflow_q <= 1'b0;
    end
  end

endmodule

// [core/brs_sequencer.v]
// brownout reset sequencer top: supply monitor to core reset
`timescale 1ns/1ps
`include "brs_defs.vh"

// How it works
// - supply above trigger starts 3 ms delay
// - reset held through delay, then countdown
// - brownout loads timer f0..ff, asserts reset
// - countdown needs threshold met and delay done
// - late threshold crossing starts countdown immediately
// - reset asserted once supply below threshold
// - shallow dip skips delay, restarts countdown
// - reset released only on timer underflow
// - internal reset acts like external reset
// - no further reset while supply stays good
// - feature disabled means no internal reset
// - data registers and ram left untouched
module brs_sequencer #(
  parameter DELAY_CYCLES = `BRS_DELAY_CYC,
  parameter PRESET_LOW   = 4'hf
) (
  input  wire                    clk,
  input  wire                    nrst,
  input  wire                    above_trigger,
  input  wire                    above_threshold,
  input  wire                    brownout_en,
  input  wire                    ext_reset_n,
  output reg                     core_reset_n_q,
  output reg                     brownout_reset_q,
  output reg  [`BRS_TIMER_W-1:0] idle_count_q,
  output reg                     counting_q
);

  // ****************************************
  // states, one-hot
  // ****************************************
  localparam [3:0] ST_LOW   = 4'b0001; // below trigger, held in reset
  localparam [3:0] ST_DELAY = 4'b0010; // power-up delay running
  localparam [3:0] ST_COUNT = 4'b0100; // idle countdown running
  localparam [3:0] ST_RUN   = 4'b1000; // reset released

  reg  [3:0]              state_q;
  reg  [3:0]              state_d;
  reg                     trig_q;
  wire                    delay_done;
  wire                    tmr_underflow;
  wire [`BRS_TIMER_W-1:0] tmr_count;
  wire                    delay_restart;
  wire                    tmr_preset;
  wire                    tmr_run;

  // supply rising across the trigger level restarts the delay
  assign delay_restart = above_trigger & ~trig_q;
  // any time the supply is under the threshold the timer is preset
  // and it is held at the preset until the countdown may start, so a supply that
  // was already good at power-up still counts the full interval
  assign tmr_preset    = ~above_threshold | (state_d == ST_LOW) | (state_d == ST_DELAY);
  // countdown only with both conditions met
  assign tmr_run       = (state_d == ST_COUNT) && above_threshold && delay_done;

  // ****************************************
  // sub-blocks
  // ****************************************
  brs_delay #(
    .CYCLES (DELAY_CYCLES)
  ) u_delay (
    .clk     (clk),
    .nrst    (nrst),
    .restart (delay_restart | ~above_trigger),
    .done_q  (delay_done)
  );

  brs_idle_timer u_timer (
    .clk         (clk),
    .nrst        (nrst),
    .preset      (tmr_preset),
    .preset_low  (PRESET_LOW),
    .run         (tmr_run),
    .count_q     (tmr_count),
    .underflow_q (tmr_underflow)
  );

  // ****************************************
  // next state
  // ****************************************
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_LOW: begin
        if (above_trigger) begin
          state_d = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (!above_trigger) begin
          state_d = ST_LOW;
        end else if (delay_done) begin
          state_d = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (!above_trigger) begin
          state_d = ST_LOW;
        end else if (tmr_underflow && above_threshold) begin
          // a late underflow pulse must not release reset into a falling supply
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        // a shallow dip goes back to counting, not to the delay
        if (!above_trigger) begin
          state_d = ST_LOW;
        end else if (!above_threshold) begin
          state_d = ST_COUNT;
        end
      end
      default: begin
        state_d = ST_LOW;
      end
    endcase
  end

  // ****************************************
  // registers and outputs
  // ****************************************
  // the sequencer only drives reset; it never clears data or ram
  always @(posedge clk) begin
    if (!nrst) begin
      state_q          <= ST_LOW;
      trig_q           <= 1'b0;
      brownout_reset_q <= 1'b1;
      core_reset_n_q   <= 1'b0;
      idle_count_q     <= `BRS_PRESET_BASE;
      counting_q       <= 1'b0;
    end else begin
      state_q      <= state_d;
      trig_q       <= above_trigger;
      idle_count_q <= tmr_count;
      counting_q   <= tmr_run;
      // reset held in every state but run; held low while disabled is avoided
      brownout_reset_q <= brownout_en & (state_d != ST_RUN);
      // one reset line for both sources so they initialise alike
      core_reset_n_q <= ext_reset_n & ~(brownout_en & (state_d != ST_RUN));
    end
  end

endmodule

// [test/brs_supply_model.sv]
// supply comparators and reset pin facing the sequencer
`timescale 1ns/1ps
module brs_supply_model (
  input  wire       pin_low,
  input  wire [1:0] lvl,
  output wire       above_trigger,
  output wire       above_threshold,
  output wire       ext_reset_n
);
  // threshold sits above trigger, so a good supply sets both
  assign above_trigger   = lvl != 2'h0;
  assign above_threshold = lvl == 2'h2;
  assign ext_reset_n     = !pin_low;
endmodule

// [test/brs_seq_props.sv]
// port assertions for the brownout reset sequencer
`timescale 1ns/1ps
module brs_seq_props #(
  parameter DELAY_CYCLES = 20,
  parameter PRESET_LOW   = 4'hf
) (
  input wire       clk,
  input wire       nrst,
  input wire       above_trigger,
  input wire       above_threshold,
  input wire       brownout_en,
  input wire       ext_reset_n,
  input wire       core_reset_n_q,
  input wire       brownout_reset_q,
  input wire [7:0] idle_count_q,
  input wire       counting_q
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  thr_low_reset_a: assert property (brownout_en && !above_threshold |=> brownout_reset_q)
    else $error("reset missing on low supply");
  preset_load_a: assert property ((brownout_en && !above_threshold) [*2] |=>
    idle_count_q == (8'hf0 | PRESET_LOW)) else $error("timer preset wrong");
  delay_hold_a: assert property (brownout_en && $rose(above_trigger) |=>
    brownout_reset_q [*8]) else $error("reset dropped in delay");
  count_gate_a: assert property (counting_q |-> $past(above_threshold))
    else $error("count without good supply");
  release_uf_a: assert property ($fell(brownout_reset_q) |-> $past(counting_q))
    else $error("release without countdown");
  stay_out_a: assert property (brownout_en && above_threshold && !brownout_reset_q |=>
    !brownout_reset_q) else $error("extra internal reset");
  no_en_reset_a: assert property (!brownout_en |=> !brownout_reset_q)
    else $error("reset while disabled");
  ext_reset_a: assert property (!ext_reset_n |=> !core_reset_n_q)
    else $error("pin reset not passed");
  core_or_a: assert property (brownout_reset_q |-> !core_reset_n_q)
    else $error("core free during reset");
  cover property ($fell(brownout_reset_q));
  cover property ($rose(counting_q));
  cover property (!brownout_en && !core_reset_n_q);
endmodule
bind brs_sequencer brs_seq_props #(.DELAY_CYCLES(DELAY_CYCLES), .PRESET_LOW(PRESET_LOW)) u_p (
  .clk(clk), .nrst(nrst), .above_trigger(above_trigger), .above_threshold(above_threshold),
  .brownout_en(brownout_en), .ext_reset_n(ext_reset_n), .core_reset_n_q(core_reset_n_q),
  .brownout_reset_q(brownout_reset_q), .idle_count_q(idle_count_q), .counting_q(counting_q));

// [test/tb.sv]
// self-checking bench for the brownout reset sequencer
`timescale 1ns/1ps
module tb;
  localparam DLY = 20; // short delay keeps the run brief
  reg        clk = 1'b0;
  reg        nrst = 1'b0;
  reg        pin_low = 1'b0;
  reg        en = 1'b1;
  reg  [1:0] lvl = 2'h0;
  wire       trig, thr, ext_n, core_n, bor, cnt;
  wire [7:0] ic;
  integer    n_errors = 0;
  integer    n_checks = 0;
  integer    cyc = 0;
  integer    i;
  // ****
  // harness
  // ****
  always #10 clk = ~clk;
  brs_supply_model u_brs_supply_model (.pin_low(pin_low), .lvl(lvl), .above_trigger(trig),
    .above_threshold(thr), .ext_reset_n(ext_n));
  brs_sequencer #(.DELAY_CYCLES(DLY)) u_brs_sequencer (.clk(clk), .nrst(nrst),
    .above_trigger(trig), .above_threshold(thr), .brownout_en(en), .ext_reset_n(ext_n),
    .core_reset_n_q(core_n), .brownout_reset_q(bor), .idle_count_q(ic), .counting_q(cnt));
  function exp_core(input e_n, input b);
    exp_core = e_n & ~b;
  endfunction
  task test_done;
    begin
      if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task check(input [31:0] nm, input [7:0] seen, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task step(input [1:0] v, input integer n);
    begin
      lvl = v;
      repeat (n) @(negedge clk);
    end
  endtask
  // release time counted from the good-supply edge; a deep dip straight to good supply adds the delay
  task span(input full);
    integer n;
    begin
      n = 0;
      while (bor !== 1'b0 && n < 600) begin
        @(negedge clk);
        n = n + 1;
      end
      check("span", n >= 256 + full * DLY && n <= 262 + full * DLY, 1'b1);
    end
  endtask
  // hang guard well above the expected two thousand or so cycles
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      test_done;
    end
  end
  initial begin
    i = $urandom(32'h56cf768e);
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    check("bor", bor, 1'b1);
    check("ic", ic, 8'hf0);
    step(2'h2, 0);
    span(1);
    check("core", core_n, exp_core(ext_n, bor));
    for (i = 0; i < 6; i = i + 1) begin
      step(2'h1, $urandom_range(8, 2));
      check("bor", bor, 1'b1);
      check("cnt", cnt, 1'b0);
      check("ic", ic, 8'hf0 | 4'hf);
      if (i[0]) step(2'h0, 3);
      if (i[0] && i != 5) step(2'h1, DLY + $urandom_range(9, 2));
      step(2'h2, 0);
      span(i == 5);
      step(2'h2, $urandom_range(40, 5));
      check("bor", bor, 1'b0);
    end
    pin_low = 1'b1;
    repeat (2) @(negedge clk);
    check("core", core_n, exp_core(ext_n, bor));
    pin_low = 1'b0;
    en = 1'b0;
    step(2'h1, 4);
    check("bor", bor, 1'b0);
    check("core", core_n, 1'b1);
    pin_low = 1'b1;
    repeat (2) @(negedge clk);
    check("core", core_n, 1'b0);
    test_done;
  end
endmodule
